// File: hw/efr_bip4.sv
/*
 * four-lane interleaved parity over one 1536-bit frame.
 * assumes the parent supplies the bit position and one bit per cycle.
 */
`timescale 1ns/1ps
module efr_bip4
  import efr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_in,
  input wire logic [10:0] pos,
  output logic [3:0] result_reg
);
  logic [3:0] acc_reg;
  logic [3:0] acc_next;
  logic [3:0] lane_hit;
  wire first_bit = (pos == 11'h000);
  wire last_bit = (pos == FRAME_LAST);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_hit[g] = bit_in & (pos[1:0] == 2'(g));
    end
  endgenerate

  assign acc_next = first_bit ? lane_hit : (acc_reg ^ lane_hit);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= 4'h0;
      result_reg <= 4'h0;
    end else begin
      acc_reg <= acc_next;
      if (last_bit) begin
        result_reg <= acc_next;
      end
    end
  end
endmodule

// File: hw/efr_tx_overhead.sv
/*
 * outbound e3 overhead insertion: framing pattern with error masks, alarm
 * bit source selection, interleaved parity nibble insertion, and the
 * inbound parity check that feeds the far-end block error flag.
 * assumes one line bit per clock on both directions and that the inbound
 * frame start pulse marks bit position zero of each received frame.
 */
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
// Notes on behaviour
// - selector 00 register, 01 overhead port, 10 payload port choose the A bit.
// - selector 11 sends far-end block error: 1 if receiver saw a parity error.
// - register source places service-bits bit 1 in every frame's A bit.
// - parity enable inserts previous frame's parity into bits 1533 to 1536.
// - the same enable bit turns on receive parity checking.
// - masks inject errors into framing pattern and parity nibble for testing.
// - framing pattern bits are xored with the two 5-bit masks.
// - parity nibble xored with parity mask, only while insertion enabled.
module efr_tx_overhead
  import efr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic payload_data,
  input wire logic overhead_data,
  output logic payload_req,
  output logic overhead_req,
  output logic line_data,
  output logic line_frame_start,
  input wire logic rx_data,
  input wire logic rx_frame_start
);
  // software registers
  logic [7:0] cfg_reg;
  logic [1:0] svc_reg;
  logic [4:0] fmask_high_reg;
  logic [4:0] fmask_low_reg;
  logic [3:0] pmask_reg;
  // per-frame copies
  logic [7:0] cfg_act_reg;
  logic [1:0] svc_act_reg;
  logic [4:0] fmask_high_act_reg;
  logic [4:0] fmask_low_act_reg;
  logic [3:0] pmask_act_reg;
  // transmit frame state
  logic [10:0] tx_pos_reg;
  logic [10:0] tx_pos_next;
  logic line_data_reg;
  logic line_start_reg;
  logic [10:0] line_pos_reg;
  logic [3:0] tx_parity;
  logic tx_parity_valid_reg;
  // receive check state
  logic [10:0] rx_pos_reg;
  logic [10:0] rx_pos;
  logic [3:0] rx_parity;
  logic rx_parity_valid_reg;
  logic rx_mismatch_reg;
  logic febe_reg;
  logic rx_err_sticky_reg;
  logic [7:0] rx_err_count_reg;
  // bus side
  logic wr_stb;
  logic [7:0] reg_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  efr_wb_slave u_wb (
    .clk(clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .rd_data(rd_data),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .wr_stb(wr_stb),
    .reg_idx(reg_idx),
    .wr_data(wr_data)
  );

  // register decode
  wire wr_cfg = wr_stb & (reg_idx == IDX_TX_FRAME_CONFIG);
  wire wr_svc = wr_stb & (reg_idx == IDX_TX_SERVICE_BITS);
  wire wr_fmh = wr_stb & (reg_idx == IDX_FRAMING_MASK_HIGH);
  wire wr_fml = wr_stb & (reg_idx == IDX_FRAMING_MASK_LOW);
  wire wr_pm = wr_stb & (reg_idx == IDX_PARITY_MASK);
  wire rd_is_cfg = (reg_idx == IDX_TX_FRAME_CONFIG);
  wire rd_is_svc = (reg_idx == IDX_TX_SERVICE_BITS);
  wire rd_is_fmh = (reg_idx == IDX_FRAMING_MASK_HIGH);
  wire rd_is_fml = (reg_idx == IDX_FRAMING_MASK_LOW);
  wire rd_is_pm = (reg_idx == IDX_PARITY_MASK);
  wire rd_is_stat = (reg_idx == IDX_RX_PARITY_STATUS);
  wire rd_is_cnt = (reg_idx == IDX_RX_PARITY_COUNT);
  wire [7:0] stat_word = {6'h00, rx_err_sticky_reg, febe_reg};

  assign rd_data = rd_is_cfg ? cfg_reg :
                   rd_is_svc ? {6'h00, svc_reg} :
                   rd_is_fmh ? {3'h0, fmask_high_reg} :
                   rd_is_fml ? {3'h0, fmask_low_reg} :
                   rd_is_pm ? {4'h0, pmask_reg} :
                   rd_is_stat ? stat_word :
                   rd_is_cnt ? rx_err_count_reg : 8'h00;

  // sticky error flag clears on status read; a new error wins
  wire stat_read = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & rd_is_stat;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= RST_TX_FRAME_CONFIG;
      svc_reg <= RST_TX_SERVICE_BITS[1:0];
      fmask_high_reg <= RST_FRAMING_MASK;
      fmask_low_reg <= RST_FRAMING_MASK;
      pmask_reg <= RST_PARITY_MASK;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= wr_data;
      end
      if (wr_svc) begin
        svc_reg <= wr_data[1:0];
      end
      if (wr_fmh) begin
        fmask_high_reg <= wr_data[4:0];
      end
      if (wr_fml) begin
        fmask_low_reg <= wr_data[4:0];
      end
      if (wr_pm) begin
        pmask_reg <= wr_data[3:0];
      end
    end
  end

  // transmit bit position
  wire tx_frame_end = (tx_pos_reg == FRAME_LAST);
  assign tx_pos_next = tx_frame_end ? 11'h000 : tx_pos_reg + 11'h001;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_act_reg <= RST_TX_FRAME_CONFIG;
      svc_act_reg <= RST_TX_SERVICE_BITS[1:0];
      fmask_high_act_reg <= RST_FRAMING_MASK;
      fmask_low_act_reg <= RST_FRAMING_MASK;
      pmask_act_reg <= RST_PARITY_MASK;
    end else if (tx_frame_end) begin
      cfg_act_reg <= cfg_reg;
      svc_act_reg <= svc_reg;
      fmask_high_act_reg <= fmask_high_reg;
      fmask_low_act_reg <= fmask_low_reg;
      pmask_act_reg <= pmask_reg;
    end
  end

  wire parity_en = cfg_act_reg[CFG_PARITY_EN_BIT];
  wire [1:0] asrc_bits = cfg_act_reg[CFG_ASRC_LSB +: 2];
  efr_asrc_e asrc;
  assign asrc = efr_asrc_e'(asrc_bits);

  // slot classification
  wire in_fas = (tx_pos_reg <= FAS_LAST);
  wire in_fas_high = (tx_pos_reg <= FAS_HIGH_LAST);
  wire in_a = (tx_pos_reg == A_POS);
  wire in_n = (tx_pos_reg == N_POS);
  wire in_parity = parity_en & (tx_pos_reg >= PARITY_FIRST);
  wire [3:0] fas_idx = 4'(FAS_LAST - tx_pos_reg);
  wire [3:0] low_idx = 4'(FAS_LAST - tx_pos_reg);
  wire [3:0] high_idx = 4'(FAS_HIGH_LAST - tx_pos_reg);

  wire fas_bit = FAS_PATTERN[fas_idx];
  wire fmask_bit = in_fas_high ? fmask_high_act_reg[high_idx[2:0]]
                               : fmask_low_act_reg[low_idx[2:0]];
  wire fas_out = fas_bit ^ fmask_bit;

  // register source uses service bit 1
  logic a_out;
  always_comb begin
    unique case (asrc)
      EFR_ASRC_REG: a_out = svc_act_reg[SVC_A_BIT];
      EFR_ASRC_OVERHEAD: a_out = overhead_data;
      EFR_ASRC_PAYLOAD: a_out = payload_data;
      EFR_ASRC_FEBE: a_out = febe_reg;
    endcase
  end

  // previous frame's parity in last nibble
  // parity mask only with insertion on
  wire par_bit = tx_parity[tx_pos_reg[1:0]] ^ pmask_act_reg[tx_pos_reg[1:0]];
  wire par_out = tx_parity_valid_reg ? par_bit : pmask_act_reg[tx_pos_reg[1:0]];

  // overhead port serves the A bit only when selected
  assign overhead_req = in_a & (asrc == EFR_ASRC_OVERHEAD);
  assign payload_req = ~in_fas & ~in_n & ~in_parity & (~in_a | (asrc == EFR_ASRC_PAYLOAD));

  logic bit_out;
  always_comb begin
    if (in_fas) begin
      bit_out = fas_out;
    end else if (in_a) begin
      bit_out = a_out;
    end else if (in_n) begin
      bit_out = svc_act_reg[SVC_N_BIT];
    end else if (in_parity) begin
      bit_out = par_out;
    end else begin
      bit_out = payload_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_pos_reg <= 11'h000;
      line_data_reg <= 1'b0;
      line_start_reg <= 1'b0;
      line_pos_reg <= 11'h000;
      tx_parity_valid_reg <= 1'b0;
    end else begin
      tx_pos_reg <= tx_pos_next;
      line_data_reg <= bit_out;
      line_start_reg <= (tx_pos_reg == 11'h000);
      line_pos_reg <= tx_pos_reg;
      // nibble valid from the first frame with insertion on
      if (line_pos_reg == FRAME_LAST) begin
        tx_parity_valid_reg <= parity_en;
      end
    end
  end

  assign line_data = line_data_reg;
  assign line_frame_start = line_start_reg;

  efr_bip4 u_tx_bip (
    .clk(clk),
    .rst(rst),
    .bit_in(line_data_reg),
    .pos(line_pos_reg),
    .result_reg(tx_parity)
  );

  // receive bit position, realigned by frame start
  assign rx_pos = rx_frame_start ? 11'h000 : rx_pos_reg;
  wire rx_last = (rx_pos == FRAME_LAST);
  wire rx_in_parity = (rx_pos >= PARITY_FIRST);
  wire rx_check_en = cfg_reg[CFG_PARITY_EN_BIT];

  efr_bip4 u_rx_bip (
    .clk(clk),
    .rst(rst),
    .bit_in(rx_data),
    .pos(rx_pos),
    .result_reg(rx_parity)
  );

  wire rx_bit_bad = rx_in_parity & (rx_data != rx_parity[rx_pos[1:0]]);
  wire rx_frame_bad = rx_mismatch_reg | rx_bit_bad;
  wire rx_judge = rx_last & rx_check_en & rx_parity_valid_reg;

  // receive check governed by the same enable
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_pos_reg <= 11'h000;
      rx_parity_valid_reg <= 1'b0;
      rx_mismatch_reg <= 1'b0;
      febe_reg <= 1'b0;
      rx_err_sticky_reg <= 1'b0;
      rx_err_count_reg <= 8'h00;
    end else begin
      rx_pos_reg <= rx_last ? 11'h000 : rx_pos + 11'h001;
      if (rx_last) begin
        rx_parity_valid_reg <= rx_check_en;
        rx_mismatch_reg <= 1'b0;
      end else if (rx_pos == 11'h000) begin
        rx_mismatch_reg <= rx_bit_bad;
      end else begin
        rx_mismatch_reg <= rx_frame_bad;
      end
      // error flag follows each judged frame
      if (rx_judge) begin
        febe_reg <= rx_frame_bad;
      end else if (~rx_check_en) begin
        febe_reg <= 1'b0;
      end
      if (rx_judge & rx_frame_bad) begin
        rx_err_sticky_reg <= 1'b1;
      end else if (stat_read) begin
        rx_err_sticky_reg <= 1'b0;
      end
      if (rx_judge & rx_frame_bad & (rx_err_count_reg != 8'hff)) begin
        rx_err_count_reg <= rx_err_count_reg + 8'h01;
      end
    end
  end
endmodule

// File: hw/efr_wb_slave.sv
/*
 * classic wishbone slave front end: decode, byte lane 0 write strobe, ack.
 * assumes 8-bit registers in the low byte of each aligned 32-bit word.
 */
`timescale 1ns/1ps
module efr_wb_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [7:0] rd_data,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic wr_stb,
  output logic [7:0] reg_idx,
  output logic [7:0] wr_data
);
  logic ack_reg;
  logic [7:0] rdat_reg;
  wire req = wb_cyc_i & wb_stb_i & ~ack_reg;

  assign reg_idx = wb_adr_i[9:2];
  assign wr_data = wb_dat_i[7:0];
  assign wr_stb = req & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {24'h00_0000, rdat_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdat_reg <= rd_data;
      end
    end
  end
endmodule

// File: shared/efr_pkg.sv
/*
 * constants for the outbound e3 overhead insertion block: register indices,
 * field positions, reset values, frame layout and alarm-bit source codes.
 * assumes one line bit per clock cycle and 8-bit registers on a 32-bit bus.
 */
package efr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_FRAME_CONFIG = 8'h30;
  localparam logic [7:0] IDX_TX_SERVICE_BITS = 8'h35;
  localparam logic [7:0] IDX_FRAMING_MASK_HIGH = 8'h48;
  localparam logic [7:0] IDX_FRAMING_MASK_LOW = 8'h49;
  localparam logic [7:0] IDX_PARITY_MASK = 8'h4a;
  localparam logic [7:0] IDX_RX_PARITY_STATUS = 8'h50;
  localparam logic [7:0] IDX_RX_PARITY_COUNT = 8'h51;
  // tx_frame_config fields
  localparam int CFG_PARITY_EN_BIT = 7;
  localparam int CFG_ASRC_LSB = 5;
  // tx_service_bits fields
  localparam int SVC_A_BIT = 1;
  localparam int SVC_N_BIT = 0;
  // reset values
  localparam logic [7:0] RST_TX_FRAME_CONFIG = 8'h00;
  localparam logic [7:0] RST_TX_SERVICE_BITS = 8'h02;
  localparam logic [4:0] RST_FRAMING_MASK = 5'h00;
  localparam logic [3:0] RST_PARITY_MASK = 4'h0;
  // frame layout, positions counted from zero
  localparam logic [10:0] FRAME_LAST = 11'h5ff;
  localparam logic [10:0] FAS_LAST = 11'h009;
  localparam logic [10:0] FAS_HIGH_LAST = 11'h004;
  localparam logic [10:0] A_POS = 11'h00a;
  localparam logic [10:0] N_POS = 11'h00b;
  localparam logic [10:0] PARITY_FIRST = 11'h5fc;
  localparam logic [9:0] FAS_PATTERN = 10'h3d0;
  typedef enum logic [1:0] {
    EFR_ASRC_REG = 2'h0,
    EFR_ASRC_OVERHEAD = 2'h1,
    EFR_ASRC_PAYLOAD = 2'h2,
    EFR_ASRC_FEBE = 2'h3
  } efr_asrc_e;
endpackage

// File: testbench/e3_tx_alarm_bit_and_parity_insert_tb_top.sv
/*
 * testbench for the outbound overhead block.
 * assumes the line model loops the outbound line back as the inbound one.
 */
`timescale 1ns/1ps
module e3_tx_alarm_bit_and_parity_insert_tb_top;
  import efr_pkg::*;
  logic clk = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, payload_req, overhead_req, line_data, line_frame_start, rx_data, rx_frame_start;
  logic payload_data = 1'h0, overhead_data = 1'h0, corrupt = 1'h0, pl_tog = 1'h0;
  logic [1535:0] last_frame, prev_frame;
  logic [7:0] rd;
  int frames, num_errors, checked, cyc_n;
  logic [7:0] ix[6] = '{IDX_TX_FRAME_CONFIG, IDX_TX_SERVICE_BITS, IDX_FRAMING_MASK_HIGH,
    IDX_FRAMING_MASK_LOW, IDX_PARITY_MASK, 8'h20};
  logic [7:0] rv[6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv[6] = '{8'h9f, 8'hff, 8'hff, 8'hff, 8'h0a, 8'h55};
  logic [7:0] wx[6] = '{8'h9f, 8'h03, 8'h1f, 8'h1f, 8'h0a, 8'h00};
  logic [1:0] src[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  efr_tx_overhead i_efr_tx_overhead (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i,
    .wb_dat_i, .wb_ack_o, .wb_dat_o, .payload_data, .overhead_data, .payload_req, .overhead_req,
    .line_data, .line_frame_start, .rx_data, .rx_frame_start);
  efr_line_model i_efr_line_model (.clk, .line_data, .line_frame_start, .corrupt, .rx_data,
    .rx_frame_start, .last_frame, .prev_frame, .frames);
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (pl_tog) payload_data <= cyc_n[0] ^ cyc_n[4];
    if (cyc_n == 80000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h00_0000, d};
    @(posedge clk);
    while (wb_ack_o !== 1'h1) @(posedge clk);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic nf(input int n);
    int t;
    t = frames + n;
    wait (frames >= t);
  endtask
  function automatic logic [3:0] par(input logic [1535:0] f);
    logic [3:0] r = 4'h0;
    for (int i = 0; i < 1536; i++) r[i % 4] ^= f[i];
    return r;
  endfunction
  function automatic logic [9:0] head(input logic [1535:0] f);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) r[9 - i] = f[i];
    return r;
  endfunction
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      wb(ix[i], 1'h0, 8'h00);
      chk(10'(rd), 10'(rv[i]));
      wb(ix[i], 1'h1, wv[i]);
      wb(ix[i], 1'h0, 8'h00);
      chk(10'(rd), 10'(wx[i]));
      wb(ix[i], 1'h1, rv[i]);
    end
  endtask
  task automatic t_fas();
    nf(1);
    wb(IDX_FRAMING_MASK_HIGH, 1'h1, 8'h15);
    wb(IDX_FRAMING_MASK_LOW, 1'h1, 8'h0a);
    nf(1);
    chk(head(last_frame), FAS_PATTERN);
    chk(10'(last_frame[11:10]), 10'h001);
    nf(1);
    chk(head(last_frame), FAS_PATTERN ^ 10'h2aa);
    wb(IDX_FRAMING_MASK_HIGH, 1'h1, 8'h00);
    wb(IDX_FRAMING_MASK_LOW, 1'h1, 8'h00);
  endtask
  task automatic t_asrc();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      overhead_data <= i == 0 || i == 3;
      payload_data <= i == 2;
      wb(IDX_TX_SERVICE_BITS, 1'h1, i == 3 ? 8'h00 : 8'h02);
      wb(IDX_TX_FRAME_CONFIG, 1'h1, {1'h0, src[i], 5'h00});
      nf(2);
      chk(10'(last_frame[10]), (i == 0 || i == 2) ? 10'h001 : 10'h000);
    end
  endtask
  task automatic t_par();
    pl_tog <= 1'h1;
    wb(IDX_PARITY_MASK, 1'h1, 8'h05);
    wb(IDX_TX_FRAME_CONFIG, 1'h1, 8'h80);
    nf(3);
    chk(10'(last_frame[1535:1532]), 10'(par(prev_frame) ^ 4'h5));
    wb(IDX_PARITY_MASK, 1'h1, 8'h00);
    nf(2);
    chk(10'(last_frame[1535:1532]), 10'(par(prev_frame)));
    pl_tog <= 1'h0;
    @(posedge clk);
    payload_data <= 1'h0;
    wb(IDX_PARITY_MASK, 1'h1, 8'h0f);
    wb(IDX_TX_FRAME_CONFIG, 1'h1, 8'h00);
    nf(2);
    chk(10'(last_frame[1535:1532]), 10'h000);
  endtask
  task automatic t_far_err();
    logic [7:0] c0;
    pl_tog <= 1'h1;
    wb(IDX_PARITY_MASK, 1'h1, 8'h00);
    wb(IDX_TX_FRAME_CONFIG, 1'h1, 8'he0);
    nf(5);
    chk(10'(last_frame[10]), 10'h000);
    wb(IDX_RX_PARITY_STATUS, 1'h0, 8'h00);
    wb(IDX_RX_PARITY_STATUS, 1'h0, 8'h00);
    chk(10'(rd[1:0]), 10'h000);
    wb(IDX_RX_PARITY_COUNT, 1'h0, 8'h00);
    c0 = rd;
    corrupt <= 1'h1;
    nf(4);
    chk(10'(last_frame[10]), 10'h001);
    wb(IDX_RX_PARITY_STATUS, 1'h0, 8'h00);
    chk(10'(rd[1:0]), 10'h003);
    wb(IDX_RX_PARITY_COUNT, 1'h0, 8'h00);
    chk(10'(rd > c0), 10'h001);
    corrupt <= 1'h0;
    nf(4);
    chk(10'(last_frame[10]), 10'h000);
  endtask
  task automatic t_rst();
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    wb(IDX_TX_FRAME_CONFIG, 1'h0, 8'h00);
    chk(10'(rd), 10'(RST_TX_FRAME_CONFIG));
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_fas();
    t_asrc();
    t_par();
    t_far_err();
    t_rst();
    wrap_up();
  end
endmodule

// File: testbench/efr_line_model.sv
/*
 * line side model: captures outbound frames and loops the line back inbound.
 * assumes line_frame_start marks position 0 of line_data.
 */
`timescale 1ns/1ps
module efr_line_model (
  input wire logic clk,
  input wire logic line_data,
  input wire logic line_frame_start,
  input wire logic corrupt,
  output logic rx_data,
  output logic rx_frame_start,
  output logic [1535:0] last_frame,
  output logic [1535:0] prev_frame,
  output int frames
);
  logic [1535:0] cur;
  int p = 2000;
  initial begin
    rx_data = 1'h0;
    rx_frame_start = 1'h0;
  end
  always @(posedge clk) begin
    if (line_frame_start) begin
      if (p == 1536) begin
        prev_frame <= last_frame;
        last_frame <= cur;
        frames <= frames + 1;
      end
      p = 0;
    end
    if (p < 1536) begin
      cur[p] <= line_data;
      p = p + 1;
    end
    // inbound bit 100 inverted while corrupt is set
    rx_data <= line_data ^ (corrupt && p == 101);
    rx_frame_start <= line_frame_start;
  end
endmodule

// File: testbench/efr_tx_overhead_asserts.sv
/*
 * port assertions for the outbound overhead block.
 * assumes a bind onto efr_tx_overhead, one clock, synchronous reset.
 */
`timescale 1ns/1ps
module efr_tx_overhead_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic payload_req,
  input wire logic overhead_req,
  input wire logic line_data,
  input wire logic line_frame_start
);
  logic [10:0] gap_reg;
  logic seen_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // cycles since the last frame start
  always_ff @(posedge clk) begin
    gap_reg <= (rst || line_frame_start) ? 11'h000 : gap_reg + 11'h001;
    seen_reg <= !rst && (seen_reg || line_frame_start);
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_fas_slots;
    !payload_req [*8];
  endsequence
  ack_follow_a: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rdata_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  frame_period_a: assert property (line_frame_start && seen_reg |-> gap_reg == 11'h5ff)
    else $error("frame length wrong");
  frame_gap_a: assert property (seen_reg |-> gap_reg <= 11'h5ff)
    else $error("frame start overdue");
  fas_slots_a: assert property (line_frame_start |-> s_fas_slots)
    else $error("payload taken in framing slots");
  a_slot_a: assert property (overhead_req |-> seen_reg && gap_reg == 11'h008)
    else $error("overhead taken outside alarm slot");
  first_start_a: assert property ($fell(rst) |-> ##[1:3] line_frame_start)
    else $error("no frame start after reset");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !line_frame_start && !line_data)
    else $error("outputs active in reset");
endmodule
bind efr_tx_overhead efr_tx_overhead_asserts i_efr_tx_overhead_asserts (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .payload_req, .overhead_req, .line_data, .line_frame_start);
